// >>> hdl/lag_pkg.sv
// package: constants and carrier types of the trunk distributor
`default_nettype none
package lag_pkg;
    localparam int LAG_NP = 8;
    localparam int LAG_NG = 6;
    localparam int LAG_MAXM = 4;
    localparam int LAG_MINM = 2;
    localparam int LAG_AW = 8;
    localparam int LAG_DW = 32;
    localparam int LAG_PW = 3;
    localparam int LAG_GW = 3;
    localparam int LAG_VW = 12;
    localparam int LAG_FW = 4;
    localparam int LAG_MW = 2;
    localparam int LAG_CW = 3;
    localparam int LAG_LINK_MBPS = 100;
    // register offsets, word addressed
    localparam logic [LAG_AW-1:0] LAG_OFF_PORT = 8'h00;
    localparam logic [LAG_AW-1:0] LAG_OFF_GVLAN = 8'h10;
    localparam logic [LAG_AW-1:0] LAG_OFF_STAT = 8'h1F;
    // field positions
    localparam int LAG_F_GRP = 0;
    localparam int LAG_F_FILT = 4;
    localparam int LAG_F_MON = 8;
    localparam int LAG_F_MEDIA = 12;
    localparam int LAG_F_FUNC = 16;
    localparam int LAG_F_CNT = 16;
    localparam int LAG_F_VLAN = 20;
    localparam int LAG_F_REJ = 0;
    // reset and default values
    localparam logic [LAG_GW-1:0] LAG_GRP_NONE = 3'h0;
    localparam logic [LAG_FW-1:0] LAG_FILT_DEF = 4'h0;
    localparam logic LAG_MON_DEF = 1'b0;
    localparam logic [LAG_VW-1:0] LAG_VLAN_DEF = 12'h001;

    typedef struct packed {
        logic valid;
        logic flood;
        logic known;
        logic [LAG_GW-1:0] group;
        logic [LAG_PW-1:0] bound;
    } lag_req_t;

    typedef struct packed {
        logic valid;
        logic ok;
        logic [LAG_PW-1:0] port;
    } lag_ans_t;

    typedef struct packed {
        logic [LAG_GW-1:0] grp;
        logic [LAG_FW-1:0] filt;
        logic mon;
        logic [LAG_VW-1:0] vlan;
    } lag_pcfg_t;
endpackage : lag_pkg
`default_nettype wire

// >>> hdl/lag_pick.sv
// next member after a start position, wrapping around
`default_nettype none
module lag_pick #(
    parameter int N = 8,
    parameter int W = 3
) (
    input wire logic [N-1:0] mask,
    input wire logic [W-1:0] start,
    output logic [W-1:0] next_idx,
    output logic found
);
    always_comb begin
        int j;
        j = 0;
        next_idx = start;
        found = 1'b0;
        for (int i = 1; i <= N; i++) begin
            j = (int'(start) + i) % N;
            if (!found && mask[j]) begin
                found = 1'b1;
                next_idx = W'(j);
            end
        end
    end
endmodule : lag_pick
`default_nettype wire

// >>> hdl/lag_distributor.sv
// trunk group configuration and member port distribution
// Operation
// R01 - at most four member ports per trunk
// R02 - four 100M members give 400M aggregate
// R03 - six trunk groups, indices one to six
// R04 - trunk functions only with two members
// R05 - member decided when new source arrives
// R06 - new sources bound to next member, rotating
// R07 - floods leave on one member chosen here
// R08 - reject members of mixed media types
// R09 - configure only equal speed links together (no speed check here; every link is taken as LAG_LINK_MBPS)
// R10 - others see trunk as one logical port
// R11 - all trunk members share trunk VLAN
// R12 - leaving port gets default filter, monitor
// R13 - port assignment empty or one group
// R14 - bound source keeps its member port
// R15 - rotation visits members only, wraps around
//
// Design decisions made here: the plain strobed port and the address map.
`default_nettype none
module lag_distributor import lag_pkg::*; #(
    parameter int NUM_PORTS = LAG_NP,
    parameter int NUM_GROUPS = LAG_NG,
    parameter int MAX_MEMBERS = LAG_MAXM
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [LAG_AW-1:0] ADDR,
    input wire logic [LAG_DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [LAG_DW-1:0] RDATA,
    input wire logic [NUM_PORTS-1:0][LAG_MW-1:0] PORT_MEDIA,
    input wire lag_req_t REQ,
    output lag_ans_t ANS,
    output logic [NUM_PORTS-1:0][LAG_GW-1:0] PORT_LOGICAL,
    output logic [NUM_PORTS-1:0][LAG_VW-1:0] PORT_VLAN,
    output logic [NUM_PORTS-1:0][LAG_FW-1:0] PORT_FILTER,
    output logic [NUM_PORTS-1:0] PORT_MONITOR,
    output logic CFG_REJECT
);
    localparam int NGI = 2 ** LAG_GW;
    localparam int AGG_MBPS = MAX_MEMBERS * LAG_LINK_MBPS; // see R02

    typedef struct packed {
        lag_pcfg_t [NUM_PORTS-1:0] cfg;
        logic [NGI-1:0][LAG_VW-1:0] gvlan;
        logic [NGI-1:0][LAG_PW-1:0] rot;
        logic [NUM_PORTS-1:0][LAG_GW-1:0] lgrp;
        logic [NUM_PORTS-1:0][LAG_VW-1:0] evlan;
        logic reject;
        logic [LAG_DW-1:0] rdata;
        lag_ans_t ans;
    } lag_state_t;

    lag_state_t st_r;
    lag_state_t st_nxt;
    logic wr_bad;
    logic [NUM_PORTS-1:0] req_mask;
    logic [LAG_PW-1:0] pick_idx;
    logic pick_found;

    function automatic logic [NUM_PORTS-1:0] member_mask(input lag_pcfg_t [NUM_PORTS-1:0] c,
                                                         input logic [LAG_GW-1:0] g);
        logic [NUM_PORTS-1:0] m;
        m = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            m[p] = (g != LAG_GRP_NONE) && (c[p].grp == g);
        end
        return m;
    endfunction : member_mask

    function automatic int count_ones(input logic [NUM_PORTS-1:0] m);
        int n;
        n = 0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            n += int'(m[p]);
        end
        return n;
    endfunction : count_ones

    function automatic logic [LAG_PW-1:0] lowest(input logic [NUM_PORTS-1:0] m);
        logic [LAG_PW-1:0] r;
        logic hit;
        r = '0;
        hit = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (!hit && m[p]) begin
                hit = 1'b1;
                r = LAG_PW'(p);
            end
        end
        return r;
    endfunction : lowest

    function automatic logic media_ok(input lag_pcfg_t [NUM_PORTS-1:0] c,
                                      input logic [NUM_PORTS-1:0][LAG_MW-1:0] md,
                                      input logic [LAG_GW-1:0] g,
                                      input logic [LAG_PW-1:0] idx);
        logic ok;
        ok = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (p != int'(idx) && c[p].grp == g && md[p] != md[idx]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : media_ok

    function automatic logic [LAG_DW-1:0] read_word(input lag_state_t s,
                                                    input logic [NUM_PORTS-1:0][LAG_MW-1:0] md,
                                                    input logic [LAG_AW-1:0] a);
        logic [LAG_DW-1:0] w;
        logic [LAG_PW-1:0] i;
        w = '0;
        i = a[LAG_PW-1:0];
        if (a[LAG_AW-1:LAG_PW] == LAG_OFF_PORT[LAG_AW-1:LAG_PW] && int'(i) < NUM_PORTS) begin
            w[LAG_F_GRP +: LAG_GW] = s.cfg[i].grp;
            w[LAG_F_FILT +: LAG_FW] = s.cfg[i].filt;
            w[LAG_F_MON] = s.cfg[i].mon;
            w[LAG_F_MEDIA +: LAG_MW] = md[i];
            w[LAG_F_FUNC] = s.lgrp[i] != LAG_GRP_NONE;
            w[LAG_F_VLAN +: LAG_VW] = s.cfg[i].vlan;
        end else if (a == LAG_OFF_STAT) begin
            w[LAG_F_REJ] = s.reject;
        end else if (a[LAG_AW-1:LAG_GW] == LAG_OFF_GVLAN[LAG_AW-1:LAG_GW] && i != LAG_GRP_NONE
                     && int'(i) <= NUM_GROUPS) begin
            w[LAG_VW-1:0] = s.gvlan[i];
            w[LAG_F_CNT +: LAG_CW] = LAG_CW'(count_ones(member_mask(s.cfg, i)));
        end
        return w;
    endfunction : read_word

    // helpers shared by the checks below
    function automatic logic cfg_legal(input lag_pcfg_t [NUM_PORTS-1:0] c);
        logic ok;
        ok = 1'b1;
        for (int g = 1; g < NGI; g++) begin
            if (count_ones(member_mask(c, LAG_GW'(g))) > MAX_MEMBERS) begin
                ok = 1'b0;
            end
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (int'(c[p].grp) > NUM_GROUPS) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : cfg_legal

    function automatic logic leave_ok(input lag_pcfg_t [NUM_PORTS-1:0] o,
                                      input lag_pcfg_t [NUM_PORTS-1:0] c);
        logic ok;
        ok = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (o[p].grp != LAG_GRP_NONE && o[p].grp != c[p].grp
                && (c[p].filt != LAG_FILT_DEF || c[p].mon != LAG_MON_DEF)) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : leave_ok

    function automatic logic vlan_ok(input lag_state_t s);
        logic ok;
        ok = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (s.lgrp[p] != LAG_GRP_NONE && s.evlan[p] != s.gvlan[s.lgrp[p]]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : vlan_ok

    // judged from the configuration and the pins, not from the next-state copy
    function automatic logic logical_ok(input lag_pcfg_t [NUM_PORTS-1:0] c,
                                        input logic [NUM_PORTS-1:0][LAG_GW-1:0] l);
        logic ok;
        logic live;
        ok = 1'b1;
        live = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            live = count_ones(member_mask(c, c[p].grp)) >= LAG_MINM;
            if (l[p] != (live ? c[p].grp : LAG_GRP_NONE)) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : logical_ok

    assign req_mask = member_mask(st_r.cfg, REQ.group);

    lag_pick #(
        .N(NUM_PORTS),
        .W(LAG_PW)
    ) u_pick (
        .mask(req_mask),
        .start(st_r.rot[REQ.group]),
        .next_idx(pick_idx),
        .found(pick_found)
    );

    always_comb begin
        logic [LAG_GW-1:0] g;
        logic [LAG_PW-1:0] idx;
        logic [NUM_PORTS-1:0] mm;
        logic func;
        g = WDATA[LAG_F_GRP +: LAG_GW];
        idx = ADDR[LAG_PW-1:0];
        mm = '0;
        func = 1'b0;
        wr_bad = 1'b0;
        st_nxt = st_r;
        st_nxt.ans.valid = 1'b0;
        st_nxt.rdata = '0;
        if (WR && ADDR[LAG_AW-1:LAG_PW] == LAG_OFF_PORT[LAG_AW-1:LAG_PW] && int'(idx) < NUM_PORTS) begin
            mm = member_mask(st_r.cfg, g);
            mm[idx] = 1'b0;
            // full group, unknown index or media mismatch refuses the whole word
            wr_bad = g != LAG_GRP_NONE && g != st_r.cfg[idx].grp
                     && (int'(g) > NUM_GROUPS || count_ones(mm) >= MAX_MEMBERS // see R01 R03 R13
                         || !media_ok(st_r.cfg, PORT_MEDIA, g, idx)); // see R08
            if (wr_bad) begin
                st_nxt.reject = 1'b1;
            end else begin
                st_nxt.cfg[idx].grp = g; // see R13
                st_nxt.cfg[idx].filt = WDATA[LAG_F_FILT +: LAG_FW];
                st_nxt.cfg[idx].mon = WDATA[LAG_F_MON];
                st_nxt.cfg[idx].vlan = WDATA[LAG_F_VLAN +: LAG_VW];
                if (st_r.cfg[idx].grp != LAG_GRP_NONE && g != st_r.cfg[idx].grp) begin
                    st_nxt.cfg[idx].filt = LAG_FILT_DEF; // see R12
                    st_nxt.cfg[idx].mon = LAG_MON_DEF; // see R12
                end
            end
        end else if (WR && ADDR[LAG_AW-1:LAG_GW] == LAG_OFF_GVLAN[LAG_AW-1:LAG_GW]
                     && idx != LAG_GRP_NONE && int'(idx) <= NUM_GROUPS) begin
            st_nxt.gvlan[idx] = WDATA[LAG_VW-1:0];
        end else if (WR && ADDR == LAG_OFF_STAT && WDATA[LAG_F_REJ]) begin
            st_nxt.reject = 1'b0;
        end
        if (RD) begin
            st_nxt.rdata = read_word(st_r, PORT_MEDIA, ADDR);
        end
        if (REQ.valid) begin
            // decision happens on the lookup, not on a timer
            func = count_ones(req_mask) >= LAG_MINM; // see R04
            st_nxt.ans.valid = 1'b1; // see R05
            st_nxt.ans.ok = func;
            st_nxt.ans.port = '0;
            if (REQ.flood) begin
                st_nxt.ans.port = lowest(req_mask); // see R07
            end else if (REQ.known && req_mask[REQ.bound]) begin
                st_nxt.ans.port = REQ.bound; // see R14
            end else if (func && pick_found) begin
                st_nxt.ans.port = pick_idx; // see R06
                st_nxt.rot[REQ.group] = pick_idx; // see R15
            end
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            func = count_ones(member_mask(st_nxt.cfg, st_nxt.cfg[p].grp)) >= LAG_MINM;
            st_nxt.lgrp[p] = func ? st_nxt.cfg[p].grp : LAG_GRP_NONE; // see R10
            st_nxt.evlan[p] = func ? st_nxt.gvlan[st_nxt.cfg[p].grp] : st_nxt.cfg[p].vlan; // see R11
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st_r <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                st_r.cfg[p].vlan <= LAG_VLAN_DEF;
                st_r.evlan[p] <= LAG_VLAN_DEF;
            end
            for (int g = 0; g < NGI; g++) begin
                st_r.gvlan[g] <= LAG_VLAN_DEF;
            end
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    assign RDATA = st_r.rdata;
    assign ANS = st_r.ans;
    assign PORT_LOGICAL = st_r.lgrp;
    assign PORT_VLAN = st_r.evlan;
    assign CFG_REJECT = st_r.reject;

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            PORT_FILTER[p] = st_r.cfg[p].filt;
            PORT_MONITOR[p] = st_r.cfg[p].mon; // see R12
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SRST);

    a_member_cap: assert property (cfg_legal(st_r.cfg) && AGG_MBPS >= LAG_LINK_MBPS) // see R01 R02 R03
        else $error("trunk group over member limit or index out of range");
    a_ans_latency: assert property (CE && REQ.valid |=> ANS.valid) // see R05
        else $error("request not answered next cycle");
    a_ok_two: assert property (CE && REQ.valid |=> ANS.ok == (count_ones($past(req_mask)) >= LAG_MINM)) // see R04
        else $error("trunk use not tied to two members");
    a_flood_low: assert property (CE && REQ.valid && REQ.flood |=> ANS.port == lowest($past(req_mask))) // see R07
        else $error("flood port not the single chosen member");
    a_known_keep: assert property (CE && REQ.valid && !REQ.flood && REQ.known && req_mask[REQ.bound]
                                   |=> ANS.port == $past(REQ.bound)) // see R14
        else $error("bound source moved to another member");
    a_new_member: assert property (CE && REQ.valid && !REQ.flood && !(REQ.known && req_mask[REQ.bound])
                                   && count_ones(req_mask) >= LAG_MINM
                                   |=> $past(req_mask[st_nxt.ans.port]) && st_r.rot[$past(REQ.group)] == ANS.port
                                   && ANS.port != $past(st_r.rot[REQ.group])) // see R06 R15
        else $error("rotation did not move to another member");
    a_media_rej: assert property (CE && wr_bad |=> CFG_REJECT && st_r.cfg == $past(st_r.cfg)) // see R08
        else $error("mixed media assignment was accepted");
    a_leave_dflt: assert property ($past(CE) |-> leave_ok($past(st_r.cfg), st_r.cfg)) // see R12
        else $error("leaving port kept filter or monitor settings");
    a_vlan_same: assert property (vlan_ok(st_r)) // see R11
        else $error("trunk member vlan differs from trunk vlan");
    a_logical_one: assert property (logical_ok(st_r.cfg, PORT_LOGICAL)) // see R10
        else $error("logical port map not updated");
endmodule : lag_distributor
`default_nettype wire

// >>> tb/lag_peer.sv
// far-side switch model: frame source that remembers the member port each source learned
`default_nettype none
module lag_peer import lag_pkg::*; (
    input wire logic clk,
    input wire logic send,
    input wire logic flood,
    input wire logic [2:0] src,
    input wire logic [LAG_GW-1:0] grp,
    output lag_req_t req,
    input wire lag_ans_t ans
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] known = 8'h00;
    logic [LAG_PW-1:0] bound [8];
    logic [2:0] last_src = 3'h0;
    logic last_flood = 1'b0;
    initial begin
        req = '0;
        foreach (bound[i]) bound[i] = 3'(i);
    end
    always @(posedge clk) begin
        req <= '0;
        if (send) begin
            req.valid <= 1'b1;
            req.flood <= flood;
            req.known <= ~flood & known[src];
            req.group <= grp;
            req.bound <= bound[src];
            last_src <= src;
            last_flood <= flood;
        end
        // floods teach nothing, refused answers forget the binding
        if (ans.valid && !last_flood) begin
            known[last_src] <= ans.ok;
            bound[last_src] <= ans.port;
        end
    end
endmodule : lag_peer
`default_nettype wire

// >>> tb/lag_distributor_tb.sv
// self-checking bench for the trunk distributor
`default_nettype none
module lag_distributor_tb import lag_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, send = 1'b0, fl = 1'b0, ce = 1'b1, rej;
    logic [LAG_NP-1:0] pmon;
    logic [LAG_AW-1:0] ADDR = 8'h00;
    logic [LAG_DW-1:0] WDATA = 32'h0000_0000;
    logic [LAG_DW-1:0] RDATA;
    logic [LAG_NP-1:0][LAG_MW-1:0] media = 16'h0400; // port 5 on another media
    lag_req_t req;
    lag_ans_t ans;
    logic [LAG_NP-1:0][LAG_GW-1:0] plog;
    logic [LAG_NP-1:0][LAG_VW-1:0] pvlan;
    logic [LAG_NP-1:0][LAG_FW-1:0] pfilt;
    logic [2:0] src = 3'h0;
    logic [LAG_GW-1:0] grp = 3'h0;
    logic [7:0] cp [8] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h62, 8'h52, 8'h77};
    int err_count = 0, n_checks = 0, seed = 32'h6c42_9979;
    int mg [8], rot [8], mk [8], mb [8];

    lag_distributor u_dut (.MCLK(MCLK), .SRST(SRST), .CE(ce), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .PORT_MEDIA(media), .REQ(req), .ANS(ans), .PORT_LOGICAL(plog), .PORT_VLAN(pvlan),
        .PORT_FILTER(pfilt), .PORT_MONITOR(pmon), .CFG_REJECT(rej));
    lag_peer u_peer (.clk(MCLK), .send(send), .flood(fl), .src(src), .grp(grp), .req(req), .ans(ans));
    initial forever #20 MCLK = ~MCLK;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
        #1;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(what, RDATA, exp);
    endtask : rdc
    function automatic int cnt(input int g);
        cnt = 0;
        for (int p = 0; p < 8; p++) cnt += int'(mg[p] == g);
    endfunction : cnt
    // model decides acceptance from group range, size and media before the write
    task automatic cfg(input int p, input int g);
        logic bad;
        bad = g != 0 && g != mg[p] && (g > 6 || cnt(g) >= 4);
        for (int q = 0; q < 8; q++) bad |= g != 0 && g != mg[p] && mg[q] == g && media[q] !== media[p];
        wr(8'(p), 32'h0010_0000 | 32'(g));
        chk("reject flag", rej, bad);
        if (bad) wr(LAG_OFF_STAT, 32'h0000_0001);
        else mg[p] = g;
        chk("reject cleared", rej, 0);
        for (int q = 0; q < 8; q++) chk("logical port", plog[q], (mg[q] != 0 && cnt(mg[q]) >= 2) ? mg[q] : 0);
    endtask : cfg
    task automatic fr(input int s, input bit f);
        int g;
        int e;
        g = s < 6 ? 1 : 2;
        e = -1;
        if (f) begin
            for (int q = 7; q >= 0; q--) if (mg[q] == g) e = q;
        end else if (mk[s] != 0 && mg[mb[s]] == g) begin
            e = mb[s];
        end else begin
            for (int i = 8; i >= 1; i--) if (mg[(rot[g] + i) % 8] == g) e = (rot[g] + i) % 8;
        end
        @(posedge MCLK);
        send <= 1'b1;
        fl <= f;
        src <= 3'(s);
        grp <= 3'(g);
        @(posedge MCLK);
        send <= 1'b0;
        @(posedge MCLK);
        #1 chk("answer valid", ans.valid, 1);
        chk("answer ok", ans.ok, cnt(g) >= 2);
        if (cnt(g) >= 2) chk("member port", ans.port, e);
        if (!f) begin
            mk[s] = int'(cnt(g) >= 2);
            mb[s] = e;
            if (cnt(g) >= 2) rot[g] = e;
        end
    endtask : fr
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5) @(posedge MCLK);
        SRST <= 1'b0;
        rdc(LAG_OFF_PORT, 32'h0010_0000, "port 0 word");
        rdc(8'h05, 32'h0010_1000, "port 5 word");
        rdc(LAG_OFF_STAT, 32'h0000_0000, "status");
        rdc(8'h40, 32'h0000_0000, "unmapped read");
        $display("test reset done");
        foreach (cp[i]) cfg(cp[i][7:4], cp[i][3:0]);
        fr(6, 1'b0);
        cfg(7, 2);
        $display("test membership done");
        // sources 0..7 learn, repeats must stick, floods stay on one port
        for (int i = 0; i < 8; i++) fr(i, 1'b0);
        fr(0, 1'b0);
        fr(1, 1'b1);
        fr(7, 1'b1);
        $display("test distribution done");
        wr(LAG_OFF_GVLAN + 8'h01, 32'h0000_00AB);
        for (int q = 0; q < 8; q++) chk("port vlan", pvlan[q], mg[q] == 1 ? 12'h0AB : 12'h001);
        rdc(LAG_OFF_GVLAN + 8'h01, 32'h0004_00AB, "group count");
        wr(8'h03, 32'h0010_0151);
        chk("member filter", pfilt[3], 4'h5);
        chk("member monitor", pmon[3], 1'b1);
        wr(8'h03, 32'h0010_01F0);
        mg[3] = 0;
        chk("left filter", pfilt[3], 4'h0);
        chk("left monitor", pmon[3], 1'b0);
        rdc(8'h03, 32'h0010_0000, "left port word");
        $display("test leave done");
        // enable low: a legal join must leave no trace
        @(posedge MCLK);
        ce <= 1'b0;
        wr(8'h04, 32'h0010_0001);
        chk("frozen port", plog[4], 0);
        @(posedge MCLK);
        ce <= 1'b1;
        rdc(8'h04, 32'h0010_0000, "frozen word");
        $display("test enable done");
        // random traffic: rebinding of sources that sat on the departed port
        repeat (40) fr($random(seed) & 7, ($random(seed) & 3) == 0);
        $display("test random done");
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        err_count++;
        $display("watchdog expired");
        tally_and_finish;
    end
endmodule : lag_distributor_tb
`default_nettype wire
